// ===== core/bfg_map.svh
// Contract
// - A newly written current code for the string picked by bit 4 starts a fade once fading is enabled.
// - A full-scale fade completes within 0.65 s or 1.3 s by rate setting.
// - Smaller changes fade proportionally faster, keeping the same ramp rate.
// - Control bit 5 picks fade time: 0 is 1.3 s, 1 is 0.65 s.
// - Control bit 4 fades the primary string at 0, secondary at 1.
// - Control bit 3 enables fading; when clear, codes apply at once.
// - Control bit 2 at 1 drives both strings from the primary code.
// - Control bits 1 and 0 switch primary and secondary sinks off or on.
// - Single-code mode with fade target 0 fades both strings together.
// - Primary code lives at 04H, secondary at 05H, 8 bits, 0.1 mA steps.
// - Three general-purpose pins; only pin 0 may serve as PWM input.
// - Pin control 06H bit 4 enables the PWM input use of pin 0.
// - Pin control bits 2:0 set each pin input at 0, output at 1.
// - With PWM input enabled, pin 0 is an input whatever its direction.
// - Output pins drive the matching bit of pin data register 07H.
// - Reading pin data returns the real pin levels in either direction.
// - Pins 1 and 2 are plain inputs or outputs, never PWM.
// - Per-string PWM gating bits at 2BH also need the pin 0 PWM enable.
// - PWM input is active high: selected string lit while pin high.
// - A serial write takes effect at the rising clock of the last ack.
`ifndef BFG_MAP_SVH
`define BFG_MAP_SVH
`define BFG_DEV_ADDR     7'h59
`define BFG_REG_BLCTL    8'h03
`define BFG_REG_PCUR     8'h04
`define BFG_REG_SCUR     8'h05
`define BFG_REG_PCTL     8'h06
`define BFG_REG_PDAT     8'h07
`define BFG_REG_GATE     8'h2b
`define BFG_MASK_BLCTL   8'h3f
`define BFG_MASK_PCTL    8'h17
`define BFG_MASK_PDAT    8'h07
`define BFG_MASK_GATE    8'h03
`define BFG_PCTL_PWM     4
`define BFG_GATE_PRI     1
`define BFG_GATE_SEC     0
`define BFG_RST_BYTE     8'h00
`define BFG_CLK_MHZ      20
`define BFG_FADE_SLOW_US 1300000
`define BFG_FADE_FAST_US 650000
`define BFG_FADE_STEPS   255
`define BFG_STEP_CYC(us) (((us) * `BFG_CLK_MHZ) / `BFG_FADE_STEPS)
`endif

// ===== core/bfg_pkg.sv
package bfg_pkg;
    typedef struct packed {
        logic [1:0] unused;
        logic       fade_fast;
        logic       fade_sel;
        logic       fade_en;
        logic       single_dac_mode;
        logic       en_primary;
        logic       en_secondary;
    } bfg_ctl_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACKA, ST_REG, ST_ACKR,
        ST_WDATA, ST_ACKW, ST_RDATA, ST_RACK
    } bfg_state_t;
endpackage

// ===== core/bfg_backlight.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfg_map.svh"
module bfg_backlight #(
    parameter int TMR_W     = 17,
    parameter int STEP_SLOW = `BFG_STEP_CYC(`BFG_FADE_SLOW_US),
    parameter int STEP_FAST = `BFG_STEP_CYC(`BFG_FADE_FAST_US)
) (
    // Clock and reset.
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Serial register port.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_o,
    // General-purpose pins.
    input  wire logic [2:0] gpio_i,
    output var  logic [2:0] gpio_o,
    output var  logic [2:0] gpio_oe_o,
    // Current sinks.
    output var  logic [7:0] main_code_o,
    output var  logic [7:0] sub_code_o,
    output var  logic       main_on_o,
    output var  logic       sub_on_o
);
    import bfg_pkg::*;

    if (STEP_FAST < 1 || STEP_SLOW < STEP_FAST ||
        STEP_SLOW >= (1 << TMR_W)) begin : g_bad
        $error("Fade step counts do not fit the timer.");
    end

    // Input synchronisers.
    logic [2:0] pin_s1, pin_s2;
    logic       scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    always_ff @(posedge clk_sys_i) begin
        pin_s1 <= gpio_i;
        pin_s2 <= pin_s1;
        scl_s1 <= scl_i;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= sda_i;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // Registers.
    bfg_ctl_t   ctl_reg, ctl_next;
    logic [7:0] pcur_reg, pcur_next, scur_reg, scur_next;
    logic [7:0] pctl_reg, pctl_next, pdat_reg, pdat_next;
    logic [7:0] gate_reg, gate_next;

    // Serial port state.
    bfg_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
    logic       oe_reg, oe_next, rw_reg, rw_next;
    logic       wr_en;
    logic [7:0] rd_val;

    // Unused positions read as zero since they are never stored.
    always_comb begin
        case (ptr_reg)
            `BFG_REG_BLCTL: rd_val = ctl_reg;
            `BFG_REG_PCUR:  rd_val = pcur_reg;
            `BFG_REG_SCUR:  rd_val = scur_reg;
            `BFG_REG_PCTL:  rd_val = pctl_reg;
            `BFG_REG_PDAT:  rd_val = {5'h00, pin_s2};
            `BFG_REG_GATE:  rd_val = gate_reg;
            default:        rd_val = `BFG_RST_BYTE;
        endcase
    end

    assign wr_en = (st_reg == ST_ACKW) && scl_rise;

    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        sh_next  = sh_reg;
        ptr_next = ptr_reg;
        oe_next  = oe_reg;
        rw_next  = rw_reg;
        if (bus_stop) begin
            st_next = ST_IDLE;
            oe_next = 1'b0;
        end else if (bus_start) begin
            st_next  = ST_ADDR;
            cnt_next = 4'h0;
            oe_next  = 1'b0;
        end else if (scl_rise) begin
            case (st_reg)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (cnt_reg != 4'h8) begin
                        sh_next  = {sh_reg[6:0], sda_s2};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                ST_RDATA: cnt_next = cnt_reg + 4'h1;
                ST_ACKW:  ptr_next = ptr_reg + 8'h01;
                ST_RACK: begin
                    if (sda_s2) begin
                        st_next = ST_IDLE;
                    end else begin
                        ptr_next = ptr_reg + 8'h01;
                    end
                end
                default: st_next = st_reg;
            endcase
        end else if (scl_fall) begin
            case (st_reg)
                ST_ADDR: begin
                    if (cnt_reg == 4'h8) begin
                        if (sh_reg[7:1] == `BFG_DEV_ADDR) begin
                            st_next = ST_ACKA;
                            oe_next = 1'b1;
                            rw_next = sh_reg[0];
                        end else begin
                            st_next = ST_IDLE;
                        end
                    end
                end
                ST_ACKA, ST_RACK: begin
                    cnt_next = 4'h0;
                    if (st_reg == ST_RACK || rw_reg) begin
                        st_next = ST_RDATA;
                        sh_next = rd_val;
                        oe_next = ~rd_val[7];
                    end else begin
                        st_next = ST_REG;
                        oe_next = 1'b0;
                    end
                end
                ST_REG: begin
                    if (cnt_reg == 4'h8) begin
                        st_next  = ST_ACKR;
                        oe_next  = 1'b1;
                        ptr_next = sh_reg;
                    end
                end
                ST_ACKR, ST_ACKW: begin
                    st_next  = ST_WDATA;
                    oe_next  = 1'b0;
                    cnt_next = 4'h0;
                end
                ST_WDATA: begin
                    if (cnt_reg == 4'h8) begin
                        st_next = ST_ACKW;
                        oe_next = 1'b1;
                    end
                end
                ST_RDATA: begin
                    if (cnt_reg == 4'h8) begin
                        st_next = ST_RACK;
                        oe_next = 1'b0;
                    end else begin
                        sh_next = {sh_reg[6:0], 1'b0};
                        oe_next = ~sh_reg[6];
                    end
                end
                default: st_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_reg  <= ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg  <= `BFG_RST_BYTE;
            ptr_reg <= `BFG_RST_BYTE;
            oe_reg  <= 1'b0;
            rw_reg  <= 1'b0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            sh_reg  <= sh_next;
            ptr_reg <= ptr_next;
            oe_reg  <= oe_next;
            rw_reg  <= rw_next;
        end
    end

    // Register writes land only at the rising clock of the final ack.
    always_comb begin
        ctl_next  = ctl_reg;
        pcur_next = pcur_reg;
        scur_next = scur_reg;
        pctl_next = pctl_reg;
        pdat_next = pdat_reg;
        gate_next = gate_reg;
        if (wr_en) begin
            case (ptr_reg)
                `BFG_REG_BLCTL: ctl_next  = sh_reg & `BFG_MASK_BLCTL;
                `BFG_REG_PCUR:  pcur_next = sh_reg;
                `BFG_REG_SCUR:  scur_next = sh_reg;
                `BFG_REG_PCTL:  pctl_next = sh_reg & `BFG_MASK_PCTL;
                `BFG_REG_PDAT:  pdat_next = sh_reg & `BFG_MASK_PDAT;
                `BFG_REG_GATE:  gate_next = sh_reg & `BFG_MASK_GATE;
                default:        gate_next = gate_reg;
            endcase
        end
    end

    // Fade timer and active codes.
    logic [TMR_W-1:0] tmr_reg, tmr_next, step_len;
    logic [7:0]       pact_reg, pact_next, sact_reg, sact_next;
    logic             tick, fade_pri, fade_sec;

    assign step_len = ctl_reg.fade_fast ? TMR_W'(STEP_FAST)
                                        : TMR_W'(STEP_SLOW);
    assign tick     = tmr_reg >= step_len - TMR_W'(1);
    assign fade_pri = ctl_reg.fade_en & ~ctl_reg.fade_sel;
    assign fade_sec = ctl_reg.fade_en & ctl_reg.fade_sel;

    // A fixed step interval keeps the ramp rate constant for any span.
    always_comb begin
        tmr_next  = tick ? '0 : tmr_reg + TMR_W'(1);
        pact_next = pact_reg;
        sact_next = sact_reg;
        if (!fade_pri) begin
            pact_next = pcur_reg;
        end else if (tick && pact_reg < pcur_reg) begin
            pact_next = pact_reg + 8'h01;
        end else if (tick && pact_reg > pcur_reg) begin
            pact_next = pact_reg - 8'h01;
        end
        if (!fade_sec) begin
            sact_next = scur_reg;
        end else if (tick && sact_reg < scur_reg) begin
            sact_next = sact_reg + 8'h01;
        end else if (tick && sact_reg > scur_reg) begin
            sact_next = sact_reg - 8'h01;
        end
    end

    // Outputs; pin 0 direction loses to the PWM input enable.
    logic [2:0] gpo_next, gpoe_next;
    logic [7:0] subc_next;
    logic       mon_next, son_next, pwm_en;
    assign pwm_en    = pctl_reg[`BFG_PCTL_PWM];
    assign gpoe_next = pctl_reg[2:0] & {2'b11, ~pwm_en};
    assign gpo_next  = pdat_reg[2:0];
    // In single-code mode the secondary follows the primary ramp too.
    assign subc_next = ctl_reg.single_dac_mode ? pact_next
                                               : sact_next;
    assign mon_next  = ctl_reg.en_primary &
        ~(pwm_en & gate_reg[`BFG_GATE_PRI] & ~pin_s2[0]);
    assign son_next  = ctl_reg.en_secondary &
        ~(pwm_en & gate_reg[`BFG_GATE_SEC] & ~pin_s2[0]);

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctl_reg     <= bfg_ctl_t'(`BFG_RST_BYTE);
            pcur_reg    <= `BFG_RST_BYTE;
            scur_reg    <= `BFG_RST_BYTE;
            pctl_reg    <= `BFG_RST_BYTE;
            pdat_reg    <= `BFG_RST_BYTE;
            gate_reg    <= `BFG_RST_BYTE;
            tmr_reg     <= '0;
            pact_reg    <= `BFG_RST_BYTE;
            sact_reg    <= `BFG_RST_BYTE;
            sda_o       <= 1'b0;
            sda_oe_o    <= 1'b0;
            gpio_o      <= 3'h0;
            gpio_oe_o   <= 3'h0;
            main_code_o <= `BFG_RST_BYTE;
            sub_code_o  <= `BFG_RST_BYTE;
            main_on_o   <= 1'b0;
            sub_on_o    <= 1'b0;
        end else begin
            ctl_reg     <= ctl_next;
            pcur_reg    <= pcur_next;
            scur_reg    <= scur_next;
            pctl_reg    <= pctl_next;
            pdat_reg    <= pdat_next;
            gate_reg    <= gate_next;
            tmr_reg     <= tmr_next;
            pact_reg    <= pact_next;
            sact_reg    <= sact_next;
            sda_o       <= 1'b0;
            sda_oe_o    <= oe_next;
            gpio_o      <= gpo_next;
            gpio_oe_o   <= gpoe_next;
            main_code_o <= pact_next;
            sub_code_o  <= subc_next;
            main_on_o   <= mon_next;
            sub_on_o    <= son_next;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    chk_pin0_pwm_input: assert property (
        pctl_reg[`BFG_PCTL_PWM] |=> !gpio_oe_o[0])
        else $error("Pin 0 driven while PWM input enabled.");
    chk_pin_drive_data: assert property (
        pctl_reg[1] |=> gpio_oe_o[1] && gpio_o[1] == $past(pdat_reg[1]))
        else $error("Output pin 1 does not drive its data bit.");
    chk_nofade_direct: assert property (
        !ctl_reg.fade_en |=> main_code_o == $past(pcur_reg))
        else $error("Code not applied at once with fading off.");
    chk_fade_step_one: assert property (
        fade_pri && !tick |=> main_code_o == $past(main_code_o))
        else $error("Primary code moved between fade steps.");
    chk_fade_step_dir: assert property (
        fade_pri && tick && pact_reg < pcur_reg
        |=> main_code_o == $past(pact_reg) + 8'h01)
        else $error("Fade step is not one code toward target.");
    chk_step_interval: assert property (
        tick && !ctl_reg.fade_fast
        |-> tmr_reg == TMR_W'(STEP_SLOW - 1))
        else $error("Slow fade step not taken at its full interval.");
    chk_single_dac_out: assert property (
        $past(ctl_reg.single_dac_mode) |-> sub_code_o == main_code_o)
        else $error("Secondary code differs in single-code mode.");
    chk_string_disable: assert property (
        !ctl_reg.en_primary |=> !main_on_o)
        else $error("Primary sink on while disabled.");
    chk_pwm_gate_low: assert property (
        pwm_en && gate_reg[`BFG_GATE_PRI] && !pin_s2[0] |=> !main_on_o)
        else $error("Primary sink lit while PWM input low.");
    chk_write_commit: assert property (
        wr_en && ptr_reg == `BFG_REG_PCTL
        |=> pctl_reg == ($past(sh_reg) & `BFG_MASK_PCTL))
        else $error("Pin control write not committed at final ack.");
    chk_reserved_zero: assert property (
        ctl_reg.unused == 2'b00 && pctl_reg[7:5] == 3'h0
        && pctl_reg[3] == 1'b0)
        else $error("Reserved control bits not zero.");
endmodule
`default_nettype wire

// ===== bench/bfg_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfg_map.svh"
module bfg_host_model (
    // Clock.
    input  wire logic       clk_sys_i,
    // Device side of the pins.
    input  wire logic       sda_oe_i,
    input  wire logic [2:0] gpio_o_i,
    input  wire logic [2:0] gpio_oe_i,
    // External level applied to undriven pins.
    input  wire logic [2:0] pin_ext_i,
    // Resolved pin levels.
    output var  logic       scl_pin_o,
    output var  logic       sda_pin_o,
    output var  logic [2:0] gpio_pin_o
);
    logic scl_q  = 1'b1;
    logic sda_q  = 1'b1;
    int   nak_count = 0;

    // The data line has a pull-up, so a released line reads high.
    assign scl_pin_o  = scl_q;
    assign sda_pin_o  = sda_q & ~sda_oe_i;
    assign gpio_pin_o = (gpio_oe_i & gpio_o_i) | (~gpio_oe_i & pin_ext_i);

    task automatic half();
        repeat (12) @(posedge clk_sys_i);
        #5;
    endtask

    // Data changes a few cycles after the clock falls, so the device
    // never sees a data edge in the same cycle as the clock edge.
    task automatic clk_bit(input logic d, output logic s);
        sda_q = d;
        half();
        scl_q = 1'b1;
        half();
        s     = sda_pin_o;
        scl_q = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #5;
    endtask

    task automatic start();
        sda_q = 1'b1;
        half();
        scl_q = 1'b1;
        half();
        sda_q = 1'b0;
        half();
        scl_q = 1'b0;
        half();
    endtask

    task automatic stop();
        sda_q = 1'b0;
        half();
        scl_q = 1'b1;
        half();
        sda_q = 1'b1;
        half();
    endtask

    task automatic put(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        if (s !== 1'b0) begin
            nak_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        put({`BFG_DEV_ADDR, 1'b0});
        put(a);
        put(d);
        stop();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic s;
        start();
        put({`BFG_DEV_ADDR, 1'b0});
        put(a);
        start();
        put({`BFG_DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(1'b1, s);
        stop();
    endtask
endmodule
`default_nettype wire

// ===== bench/backlight_fade_and_gpio_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfg_map.svh"
module backlight_fade_and_gpio_tb;
    localparam int SLOW  = 20;
    localparam int FAST  = 10;
    localparam int LIMIT = 80000;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       scl, sda, sda_o, sda_oe, main_on, sub_on;
    logic [2:0] gpio_in, gpio_o, gpio_oe;
    logic [2:0] pin_ext = 3'h0;
    logic [7:0] main_code, sub_code, rdv;
    int         fail_count = 0;
    int         tests_run  = 0;
    int         cycles     = 0;

    always #25 clk = ~clk;

    bfg_backlight #(.STEP_SLOW(SLOW), .STEP_FAST(FAST)) DUT (
        .clk_sys_i(clk), .reset_i(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .gpio_i(gpio_in),
        .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .main_code_o(main_code),
        .sub_code_o(sub_code), .main_on_o(main_on), .sub_on_o(sub_on));

    bfg_host_model host (
        .clk_sys_i(clk), .sda_oe_i(sda_oe), .gpio_o_i(gpio_o),
        .gpio_oe_i(gpio_oe), .pin_ext_i(pin_ext), .scl_pin_o(scl),
        .sda_pin_o(sda), .gpio_pin_o(gpio_in));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rdv);
        chk8(rdv, exp);
    endtask

    task automatic settle();
        repeat (6) @(posedge clk);
        #5;
    endtask

    function automatic logic [7:0] code(input logic s);
        return s ? sub_code : main_code;
    endfunction

    // The step interval is measured between two later steps, since the
    // free-running timer makes the first step land anywhere in its period.
    task automatic fade_chk(input logic s, input logic [7:0] tgt,
                            input int step);
        logic [7:0] last;
        int         n;
        for (int k = 0; k < 2; k++) begin
            last = code(s);
            n    = 0;
            while (code(s) === last && n < 4 * step) begin
                @(posedge clk);
                #5;
                n++;
            end
        end
        chk_cnt(n, step);
        n = 0;
        while (code(s) !== tgt && n < 300 * step) begin
            @(posedge clk);
            #5;
            n++;
        end
        chk8(code(s), tgt);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #5;
        rst = 1'b0;
        repeat (5) @(posedge clk);
        #5;
        for (int a = 3; a < 8; a++) rd_chk(8'(a), 8'h00);
        rd_chk(8'h20, 8'h00);
        chk8({7'h0, sda_o}, 8'h00);
        end_test("reset");
        host.wr(`BFG_REG_BLCTL, 8'hff);
        rd_chk(`BFG_REG_BLCTL, 8'h3f);
        host.wr(`BFG_REG_PCTL, 8'hef);
        rd_chk(`BFG_REG_PCTL, 8'h07);
        host.wr(8'h20, 8'h5a);
        rd_chk(8'h20, 8'h00);
        chk_cnt(host.nak_count, 0);
        end_test("masks");
        host.wr(`BFG_REG_PCTL, 8'h00);
        host.wr(`BFG_REG_BLCTL, 8'h03);
        host.wr(`BFG_REG_PCUR, 8'ha5);
        host.wr(`BFG_REG_SCUR, 8'h3c);
        chk8(main_code, 8'ha5);
        chk8(sub_code, 8'h3c);
        rd_chk(`BFG_REG_SCUR, 8'h3c);
        chk8({6'h0, main_on, sub_on}, 8'h03);
        host.wr(`BFG_REG_BLCTL, 8'h02);
        chk8({6'h0, main_on, sub_on}, 8'h02);
        host.wr(`BFG_REG_BLCTL, 8'h07);
        chk8(sub_code, 8'ha5);
        end_test("direct");
        host.wr(`BFG_REG_BLCTL, 8'h0b);
        host.wr(`BFG_REG_PCUR, 8'hb5);
        fade_chk(1'b0, 8'hb5, SLOW);
        host.wr(`BFG_REG_SCUR, 8'h40);
        chk8(sub_code, 8'h40);
        host.wr(`BFG_REG_BLCTL, 8'h2b);
        host.wr(`BFG_REG_PCUR, 8'ha5);
        fade_chk(1'b0, 8'ha5, FAST);
        host.wr(`BFG_REG_BLCTL, 8'h1b);
        host.wr(`BFG_REG_SCUR, 8'h50);
        fade_chk(1'b1, 8'h50, SLOW);
        host.wr(`BFG_REG_PCUR, 8'h30);
        chk8(main_code, 8'h30);
        host.wr(`BFG_REG_BLCTL, 8'h0f);
        host.wr(`BFG_REG_PCUR, 8'h40);
        fade_chk(1'b1, 8'h40, SLOW);
        end_test("fade");
        pin_ext = 3'b010;
        host.wr(`BFG_REG_PCTL, 8'h05);
        host.wr(`BFG_REG_PDAT, 8'hfd);
        chk8({5'h0, gpio_oe}, 8'h05);
        chk8({5'h0, gpio_o}, 8'h05);
        rd_chk(`BFG_REG_PDAT, 8'h07);
        pin_ext = 3'b000;
        rd_chk(`BFG_REG_PDAT, 8'h05);
        host.wr(`BFG_REG_PDAT, 8'h00);
        rd_chk(`BFG_REG_PDAT, 8'h00);
        end_test("pins");
        host.wr(`BFG_REG_BLCTL, 8'h03);
        host.wr(`BFG_REG_PCTL, 8'h17);
        chk8({5'h0, gpio_oe}, 8'h06);
        host.wr(`BFG_REG_GATE, 8'h02);
        settle();
        chk8({6'h0, main_on, sub_on}, 8'h01);
        pin_ext = 3'b001;
        settle();
        chk8({6'h0, main_on, sub_on}, 8'h03);
        host.wr(`BFG_REG_GATE, 8'h01);
        pin_ext = 3'b000;
        settle();
        chk8({6'h0, main_on, sub_on}, 8'h02);
        rd_chk(`BFG_REG_GATE, 8'h01);
        host.wr(`BFG_REG_PCTL, 8'h06);
        settle();
        chk8({6'h0, main_on, sub_on}, 8'h03);
        end_test("pwm");
        give_verdict();
    end
endmodule
`default_nettype wire
